/* rtl/caller_id_map.svh */
// Register map, field positions, reset values and timing constants
`ifndef CALLER_ID_MAP_SVH
`define CALLER_ID_MAP_SVH
`define IDX_TX_CONTROL 6'h10
`define IDX_TX_BYTE 6'h11
`define IDX_QUEUE_STATE 6'h12
`define IDX_SIGNAL_GAIN 6'h13
`define IDX_SIGNAL_ROUTE 6'h14
`define IDX_IRQ_PENDING_TWO 6'h28
`define IDX_IRQ_ENABLE_TWO 6'h29
`define CTL_STD_BIT 0
`define CTL_PACKAGE_BIT 1
`define CTL_STOP_BIT 2
`define CTL_TX_BIT 3
`define CTL_ALERT_BIT 4
`define CTL_OFFHOOK_BIT 5
`define QUEUE_STATE_BIT 2
`define SHIFT_EMPTY_BIT 0
`define ROUTE_SELECT_BIT 1
`define CALLER_IRQ_BIT 7
`define RST_CONTROL 8'h00
`define RST_GAIN 8'h08
`define RST_ROUTE 8'h00
`define RST_ENABLE 8'h00
`define QUEUE_DEPTH 8
`define CLK_HZ 100000000
`define BAUD_HZ 1200
`define BELL_MARK_HZ 1200
`define BELL_SPACE_HZ 2200
`define V23_MARK_HZ 1300
`define V23_SPACE_HZ 2100
`define ALERT_LOW_HZ 2130
`define ALERT_HIGH_HZ 2750
`define PHASE_BITS 24
`endif

/* rtl/caller_id_pkg.sv */
// Types shared by the caller-ID generator
package caller_id_pkg;
    typedef enum logic [2:0] {
        SER_IDLE,
        SER_START,
        SER_DATA,
        SER_STOP
    } ser_state_type;
    typedef struct packed {
        logic active;
        logic route;
        logic signed [15:0] sample;
    } tone_out_type;
endpackage

/* rtl/caller_id_fsk_generator.sv */
// Caller-ID FSK generator with AXI4-Lite registers and transmit queue
`timescale 1ns/1ps
`include "caller_id_map.svh"

////////////////////////////////////////////////////////////////////////////////
module caller_byte_queue #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `QUEUE_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (count_ff != '0);
    assign out_data_o = mem[rd_ptr_ff];
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data_i;
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
            if (pop) rd_ptr_ff <= AW'(rd_ptr_ff + 1'b1);
            count_ff <= (AW+1)'(count_ff + push - pop);
        end
    end
endmodule // caller_byte_queue

////////////////////////////////////////////////////////////////////////////////
module caller_id_fsk_generator
    import caller_id_pkg::*;
#(
    parameter int BIT_CYCLES = `CLK_HZ / `BAUD_HZ
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output tone_out_type tone_o,
    output logic caller_irq_o
);
    function automatic logic [23:0] step_of(input int hz);
        step_of = 24'((64'(hz) << `PHASE_BITS) / 64'(`CLK_HZ));
    endfunction
    function automatic logic signed [15:0] tri_of(input logic [23:0] ph);
        logic [14:0] fold;
        fold = ph[23] ? ~ph[22:8] : ph[22:8];
        tri_of = 16'({1'b0, fold}) - 16'h4000;
    endfunction
    function automatic logic [5:0] idx_of(input logic [7:0] addr);
        idx_of = addr[7:2];
    endfunction
    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = idx == `IDX_TX_CONTROL || idx == `IDX_TX_BYTE ||
            idx == `IDX_SIGNAL_GAIN || idx == `IDX_SIGNAL_ROUTE ||
            idx == `IDX_IRQ_PENDING_TWO || idx == `IDX_IRQ_ENABLE_TWO;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register bus
    logic [7:0] aw_addr_ff;
    logic aw_full_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic w_full_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic [7:0] control_ff;
    logic [7:0] gain_ff;
    logic [7:0] route_ff;
    logic [7:0] enable_ff;
    logic pending_ff;
    ser_state_type state_ff;
    logic queue_ready;
    logic queue_valid;
    logic [7:0] queue_data;
    logic pop;
    logic tx_done;

    assign s_axi_awready_o = !aw_full_ff && !bvalid_ff;
    assign s_axi_wready_o = !w_full_ff && !bvalid_ff;
    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o = bresp_ff;
    assign s_axi_arready_o = !rvalid_ff;
    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rresp_o = rresp_ff;
    assign s_axi_rdata_o = rdata_ff;

    wire wr_go = aw_full_ff && w_full_ff && !bvalid_ff;
    wire [5:0] wr_idx = idx_of(aw_addr_ff);
    wire wr_lane = wr_go && w_strb_ff[0];
    wire [7:0] wr_byte = w_data_ff[7:0];
    wire wr_ctl = wr_lane && wr_idx == `IDX_TX_CONTROL;
    wire wr_tx = wr_lane && wr_idx == `IDX_TX_BYTE;
    wire wr_gain = wr_lane && wr_idx == `IDX_SIGNAL_GAIN;
    wire wr_route = wr_lane && wr_idx == `IDX_SIGNAL_ROUTE;
    wire wr_pend = wr_lane && wr_idx == `IDX_IRQ_PENDING_TWO;
    wire wr_en = wr_lane && wr_idx == `IDX_IRQ_ENABLE_TWO;
    wire wr_hit = is_mapped(wr_idx);

    wire rd_go = s_axi_arvalid_i && s_axi_arready_o;
    wire [5:0] rd_idx = idx_of(s_axi_araddr_i);
    wire [7:0] queue_state = 8'(
        ((!queue_ready) << `QUEUE_STATE_BIT) |
        ((state_ff == SER_IDLE) << `SHIFT_EMPTY_BIT));
    wire [7:0] pend_view = 8'(pending_ff << `CALLER_IRQ_BIT);
    wire rd_hit = is_mapped(rd_idx) || rd_idx == `IDX_QUEUE_STATE;
    wire [7:0] rd_byte =
        rd_idx == `IDX_TX_CONTROL ? control_ff :
        rd_idx == `IDX_QUEUE_STATE ? queue_state :
        rd_idx == `IDX_SIGNAL_GAIN ? gain_ff :
        rd_idx == `IDX_SIGNAL_ROUTE ? route_ff :
        rd_idx == `IDX_IRQ_PENDING_TWO ? pend_view :
        rd_idx == `IDX_IRQ_ENABLE_TWO ? enable_ff : 8'h00;
    wire rd_ok = rd_hit && rd_idx != `IDX_TX_BYTE;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aw_addr_ff <= 8'h00;
            aw_full_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            w_full_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_addr_ff <= s_axi_awaddr_i;
                aw_full_ff <= 1'b1;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_data_ff <= s_axi_wdata_i;
                w_strb_ff <= s_axi_wstrb_i;
                w_full_ff <= 1'b1;
            end
            if (wr_go) begin
                aw_full_ff <= 1'b0;
                w_full_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? 2'h0 : 2'h2;
            end else if (bvalid_ff && s_axi_bready_i) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= 2'h0;
            rdata_ff <= 32'h0000_0000;
        end else if (rd_go) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_ok ? 2'h0 : 2'h2;
            rdata_ff <= {24'h00_0000, rd_byte};
        end else if (s_axi_rready_i) begin
            rvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers and pending flag
    wire [7:0] nxt_control = wr_ctl ? wr_byte :
        (tx_done ? control_ff & ~8'(1 << `CTL_TX_BIT) : control_ff);
    logic queue_valid_d_ff;
    wire queue_drained = queue_valid_d_ff && !queue_valid;
    wire nxt_pending = queue_drained ||
        (pending_ff && !(wr_pend && wr_byte[`CALLER_IRQ_BIT]));

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            control_ff <= `RST_CONTROL;
            gain_ff <= `RST_GAIN;
            route_ff <= `RST_ROUTE;
            enable_ff <= `RST_ENABLE;
            pending_ff <= 1'b0;
            queue_valid_d_ff <= 1'b0;
        end else begin
            control_ff <= nxt_control;
            if (wr_gain) gain_ff <= {4'h0, wr_byte[3:0]};
            if (wr_route) route_ff <= wr_byte;
            if (wr_en) enable_ff <= wr_byte;
            pending_ff <= nxt_pending;
            queue_valid_d_ff <= queue_valid;
        end
    end
    assign caller_irq_o = pending_ff && enable_ff[`CALLER_IRQ_BIT];

    caller_byte_queue #(
        .WIDTH(8),
        .DEPTH(`QUEUE_DEPTH)
    ) u_queue (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(wr_tx),
        .in_ready_o(queue_ready),
        .in_data_i(wr_byte),
        .out_valid_o(queue_valid),
        .out_ready_i(pop),
        .out_data_o(queue_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Serialiser
    logic [7:0] shift_ff;
    logic [2:0] bit_ff;
    logic [31:0] tick_ff;
    wire tx_on = control_ff[`CTL_TX_BIT];
    wire framed = control_ff[`CTL_PACKAGE_BIT];
    wire two_stop = control_ff[`CTL_STOP_BIT];
    wire bit_end = tick_ff == 32'(BIT_CYCLES - 1);
    wire data_end = state_ff == SER_DATA && bit_end && bit_ff == 3'h7;
    wire stop_end = state_ff == SER_STOP && bit_end &&
        (bit_ff == 3'h1 || !two_stop);
    wire byte_end = stop_end || (data_end && !framed);
    wire want_next = (state_ff == SER_IDLE && tx_on) || byte_end;
    assign pop = want_next && queue_valid;
    assign tx_done = want_next && !queue_valid;
    ser_state_type nxt_state;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SER_IDLE,
            SER_STOP: begin
                if (pop) nxt_state = framed ? SER_START : SER_DATA;
                else if (want_next || state_ff == SER_IDLE) nxt_state = SER_IDLE;
            end
            SER_START: begin
                if (bit_end) nxt_state = SER_DATA;
            end
            SER_DATA: begin
                if (data_end && framed) nxt_state = SER_STOP;
                else if (pop) nxt_state = SER_DATA;
                else if (data_end) nxt_state = SER_IDLE;
            end
            default: nxt_state = SER_IDLE;
        endcase
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= SER_IDLE;
            shift_ff <= 8'h00;
            bit_ff <= 3'h0;
            tick_ff <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            tick_ff <= (pop || bit_end || state_ff == SER_IDLE) ? '0 :
                32'(tick_ff + 1'b1);
            if (pop) begin
                shift_ff <= queue_data;
                bit_ff <= 3'h0;
            end else if (bit_end && state_ff == SER_DATA) begin
                shift_ff <= {1'b0, shift_ff[7:1]};
                bit_ff <= 3'(bit_ff + 1'b1);
            end else if (data_end || (bit_end && state_ff == SER_STOP)) begin
                bit_ff <= 3'(bit_ff + 1'b1);
            end
            if (data_end) bit_ff <= 3'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tone engine: one FSK tone, or two summed alert tones
    wire mark = state_ff == SER_STOP || (state_ff == SER_DATA && shift_ff[0]);
    wire v23 = control_ff[`CTL_STD_BIT];
    wire [23:0] mark_step = v23 ? step_of(`V23_MARK_HZ) :
        step_of(`BELL_MARK_HZ);
    wire [23:0] space_step = v23 ? step_of(`V23_SPACE_HZ) :
        step_of(`BELL_SPACE_HZ);
    wire keying = state_ff != SER_IDLE;
    wire alert = control_ff[`CTL_ALERT_BIT] && !keying;
    logic [23:0] phase_a_ff;
    logic [23:0] phase_b_ff;
    tone_out_type tone_ff;
    wire [23:0] step_a = alert ? step_of(`ALERT_LOW_HZ) :
        (mark ? mark_step : space_step);
    wire signed [16:0] raw = alert ?
        17'((tri_of(phase_a_ff) >>> 1) + (tri_of(phase_b_ff) >>> 1)) :
        17'(tri_of(phase_a_ff));
    wire signed [21:0] scaled = 22'(raw * $signed({1'b0, gain_ff[3:0]}));
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_a_ff <= 24'h00_0000;
            phase_b_ff <= 24'h00_0000;
            tone_ff <= '0;
        end else begin
            phase_a_ff <= 24'(phase_a_ff + step_a);
            phase_b_ff <= alert ? 24'(phase_b_ff + step_of(`ALERT_HIGH_HZ)) :
                24'h00_0000;
            tone_ff.active <= keying || alert;
            tone_ff.route <= route_ff[`ROUTE_SELECT_BIT];
            tone_ff.sample <= (keying || alert) ? 16'(scaled >>> 4) :
                16'h0000;
        end
    end
    assign tone_o = tone_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_full_drop: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        wr_tx && !queue_ready && !pop |=> $stable(u_queue.count_ff))
        else $error("write to full queue changed it");
    a_full_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        queue_state[`QUEUE_STATE_BIT] == (u_queue.count_ff == 4'h8))
        else $error("queue full bit wrong");
    a_start_needs_tx: assert property (@(posedge ref_clk_i)
        disable iff (!rst_b_i)
        state_ff == SER_IDLE && !tx_on |=> state_ff == SER_IDLE)
        else $error("send began without transmit bit");
    a_start_space: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        pop && framed |=> state_ff == SER_START && !mark)
        else $error("start bit missing");
    a_raw_no_frame: assert property (@(posedge ref_clk_i)
        disable iff (!rst_b_i)
        pop && !framed |=> state_ff == SER_DATA)
        else $error("framing added without package mode");
    a_lsb_first: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        pop |=> shift_ff == $past(queue_data))
        else $error("byte not loaded for lsb first");
    a_irq_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        queue_drained |=> pending_ff)
        else $error("pending not set on empty queue");
    a_irq_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        pending_ff && !wr_pend |=> pending_ff)
        else $error("pending flag lost without clear");
    a_tx_ends: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        tx_done && !wr_ctl |=> !tx_on ##1 state_ff == SER_IDLE)
        else $error("transmit bit left set after last byte");
    a_phase_cont: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $changed(mark) && keying |-> phase_a_ff ==
        24'($past(phase_a_ff) + $past(step_a)))
        else $error("phase jumped");
    c_framed_byte: cover property (@(posedge ref_clk_i) stop_end);
    c_raw_byte: cover property (@(posedge ref_clk_i) data_end && !framed);
    c_alert: cover property (@(posedge ref_clk_i) alert);
    c_full: cover property (@(posedge ref_clk_i) wr_tx && !queue_ready);
endmodule // caller_id_fsk_generator

/* verification/tb_top.sv */
// Self-checking bench for the caller-ID generator over AXI4-Lite
`timescale 1ns/1ps
`include "caller_id_map.svh"

////////////////////////////////////////////////////////////////////////////////
module tb_top
    import caller_id_pkg::*;
;
    localparam int BC = 16;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, caller_irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    tone_out_type tone;
    int failures = 0, tests_run = 0, cyc = 0;
    logic nz_seen = 1'b0, act_seen = 1'b0;
    logic seen_clr = 1'b0;

    caller_id_fsk_generator #(.BIT_CYCLES(BC)) caller_id_fsk_generator_inst (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .tone_o(tone), .caller_irq_o(caller_irq));

    always #5 ref_clk_i = ~ref_clk_i;

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (seen_clr) begin
            nz_seen <= 1'b0;
            act_seen <= 1'b0;
        end else begin
            if (tone.sample !== 16'h0000) nz_seen <= 1'b1;
            if (tone.active === 1'b1) act_seen <= 1'b1;
        end
    end

    task automatic clear_seen();
        seen_clr <= 1'b1;
        @(posedge ref_clk_i);
        seen_clr <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (failures == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] adr(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction

    task automatic wr(input logic [5:0] idx, input logic [31:0] d,
                      output logic [1:0] resp);
        bit aw_done, w_done, b_done;
        int n;
        aw_done = 0; w_done = 0; b_done = 0; n = 0;
        @(posedge ref_clk_i);
        awaddr <= adr(idx); awvalid <= 1'b1;
        wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1; bready <= 1'b1;
        while (!b_done && n < 200) begin
            @(posedge ref_clk_i);
            n++;
            if (!aw_done && awvalid && awready) begin
                aw_done = 1; awvalid <= 1'b0;
            end
            if (!w_done && wvalid && wready) begin
                w_done = 1; wvalid <= 1'b0;
            end
            if (bvalid && bready) begin
                b_done = 1; resp = bresp;
            end
        end
        bready <= 1'b0;
        if (!b_done) chk(32'h0, 32'h1);
    endtask

    task automatic rd(input logic [5:0] idx, output logic [31:0] d,
                      output logic [1:0] resp);
        bit ar_done, r_done;
        int n;
        ar_done = 0; r_done = 0; n = 0;
        @(posedge ref_clk_i);
        araddr <= adr(idx); arvalid <= 1'b1; rready <= 1'b1;
        while (!r_done && n < 200) begin
            @(posedge ref_clk_i);
            n++;
            if (!ar_done && arvalid && arready) begin
                ar_done = 1; arvalid <= 1'b0;
            end
            if (rvalid && rready) begin
                r_done = 1; d = rdata; resp = rresp;
            end
        end
        rready <= 1'b0;
        if (!r_done) chk(32'h0, 32'h1);
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp,
                          input logic [1:0] exp_resp);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, exp_resp});
    endtask

    task automatic wr_ok(input logic [5:0] idx, input logic [31:0] d);
        logic [1:0] r;
        wr(idx, d, r);
        chk({30'h0, r}, 32'h0);
    endtask

    // Loads n bytes, starts sending with ctrl, checks duration in bit times
    task automatic run_tx(input logic [7:0] ctrl, input int n, input int bits);
        logic [31:0] d;
        logic [1:0] r;
        int t0, k;
        for (k = 0; k < n; k++) wr_ok(`IDX_TX_BYTE, 32'hA5 + k);
        clear_seen();
        wr_ok(`IDX_TX_CONTROL, {24'h0, ctrl | 8'h08});
        t0 = cyc;
        k = 0;
        d = 32'h1;
        while (d[`SHIFT_EMPTY_BIT] !== 1'b0 && k < 20) begin
            rd(`IDX_QUEUE_STATE, d, r); k++;
        end
        k = 0;
        while (d[`SHIFT_EMPTY_BIT] !== 1'b1 && k < 3000) begin
            rd(`IDX_QUEUE_STATE, d, r); k++;
        end
        t0 = cyc - t0 - bits * BC;
        chk(32'(t0 > -12 && t0 < 12), 32'h1);
        rd_chk(`IDX_TX_CONTROL, {24'h0, ctrl & 8'hF7}, 2'b00);
        repeat (4) @(posedge ref_clk_i);
        chk({31'h0, tone.active}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [1:0] r;
        int k;
        repeat (20) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        rd_chk(`IDX_TX_CONTROL, 32'h00, 2'b00);
        rd_chk(`IDX_SIGNAL_GAIN, 32'h08, 2'b00);
        rd_chk(`IDX_SIGNAL_ROUTE, 32'h00, 2'b00);
        rd_chk(`IDX_QUEUE_STATE, 32'h01, 2'b00);
        rd_chk(`IDX_IRQ_ENABLE_TWO, 32'h00, 2'b00);
        rd_chk(6'h3F, 32'h00, 2'b10);
        rd_chk(`IDX_TX_BYTE, 32'h00, 2'b10);
        wr(6'h3F, 32'hFF, r);
        chk({30'h0, r}, 32'h2);
        // Fill the queue, hold off sending, then overflow it
        for (k = 0; k < 7; k++) wr_ok(`IDX_TX_BYTE, 32'h30 + k);
        rd_chk(`IDX_QUEUE_STATE, 32'h01, 2'b00);
        wr_ok(`IDX_TX_BYTE, 32'h37);
        repeat (3 * BC) @(posedge ref_clk_i);
        rd_chk(`IDX_QUEUE_STATE, 32'h05, 2'b00);
        run_tx(8'h00, 1, 64);
        chk({31'h0, act_seen}, 32'h1);
        chk({31'h0, nz_seen}, 32'h1);
        // Pending flag with and without enable
        rd_chk(`IDX_IRQ_PENDING_TWO, 32'h80, 2'b00);
        chk({31'h0, caller_irq}, 32'h0);
        wr_ok(`IDX_IRQ_ENABLE_TWO, 32'h80);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, caller_irq}, 32'h1);
        wr_ok(`IDX_IRQ_PENDING_TWO, 32'h80);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, caller_irq}, 32'h0);
        rd_chk(`IDX_IRQ_PENDING_TWO, 32'h00, 2'b00);
        // Framing variants on two bytes, both standards
        run_tx(8'h02, 2, 20);
        run_tx(8'h07, 2, 22);
        run_tx(8'h21, 2, 16);
        chk({31'h0, caller_irq}, 32'h1);
        // Zero gain silences the keyed signal, route bit follows
        wr_ok(`IDX_SIGNAL_GAIN, 32'h00);
        rd_chk(`IDX_SIGNAL_GAIN, 32'h00, 2'b00);
        run_tx(8'h00, 1, 8);
        chk({31'h0, nz_seen}, 32'h0);
        wr_ok(`IDX_SIGNAL_GAIN, 32'h0C);
        wr_ok(`IDX_SIGNAL_ROUTE, 32'h02);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, tone.route}, 32'h1);
        // Alerting tones while not keying
        clear_seen();
        wr_ok(`IDX_TX_CONTROL, 32'h10);
        repeat (200) @(posedge ref_clk_i);
        chk({31'h0, nz_seen}, 32'h1);
        wr_ok(`IDX_TX_CONTROL, 32'h00);
        report_and_stop();
    end

    initial begin
        repeat (40000) @(posedge ref_clk_i);
        failures++;
        report_and_stop();
    end
endmodule // tb_top
